// ### core/pap_cfg.svh
// Purpose: Named offsets, reset values, bit positions and counts of the port A pin logic.
// Assumes: Included by bare name from the bus slave and top design files and from the bench.
// Notes:   Definitions only; the guard keeps double inclusion harmless.
`ifndef PAP_CFG_SVH
`define PAP_CFG_SVH

// ****************************************************************
// Register map, byte addresses on the 32-bit register bus
// ****************************************************************
`define PAP_OFF_PIN      8'h00
`define PAP_OFF_LAT      8'h04
`define PAP_OFF_DIR      8'h08
`define PAP_OFF_ANA      8'h0c

// ****************************************************************
// Reset values and implemented-bit masks
// ****************************************************************
`define PAP_RST_LAT      8'h00
`define PAP_RST_DIR      8'hff
`define PAP_RST_ANA      8'h2f
`define PAP_ANA_MASK     8'h2f

// ****************************************************************
// Pin positions with alternate functions
// ****************************************************************
`define PAP_BIT_VREF     2
`define PAP_BIT_C1       4
`define PAP_BIT_C2       5
`define PAP_BIT_OSC_FB   6
`define PAP_BIT_OSC_IN   7

// ****************************************************************
// Cycle clock is the system clock divided by four
// ****************************************************************
`define PAP_CYC_DIV      3'h4
`define PAP_CYC_HALF     2'h2

// ****************************************************************
// Bus response codes
// ****************************************************************
`define PAP_RESP_OKAY    2'h0
`define PAP_RESP_SLVERR  2'h2

`endif

// ### core/pap_pkg.sv
// Purpose: Types shared by the port A pin logic and its register bus slave.
// Assumes: Used only through scoped names, never imported.
// Notes:   Oscillator modes are a plain encoding; state codes are one-hot.
package pap_pkg;

    // Oscillator configuration as seen by the port.
    typedef enum logic [2:0] {
        PAP_OSC_CRYSTAL        = 3'h0,
        PAP_OSC_RC_CLOCK_OUT   = 3'h1,
        PAP_OSC_RC_WITH_IO     = 3'h2,
        PAP_OSC_INT_CLOCK_OUT  = 3'h3,
        PAP_OSC_INT_WITH_IO    = 3'h4,
        PAP_OSC_EXT_CLOCK_OUT  = 3'h5,
        PAP_OSC_EXT_WITH_IO    = 3'h6
    } pap_osc_mode_t;

    // Write channel states of the bus slave.
    typedef enum logic [1:0] {
        PAP_WS_COLLECT = 2'h1,
        PAP_WS_RESP    = 2'h2
    } pap_wstate_t;

    // Read channel states of the bus slave.
    typedef enum logic [1:0] {
        PAP_RS_IDLE = 2'h1,
        PAP_RS_RESP = 2'h2
    } pap_rstate_t;

endpackage : pap_pkg

// ### core/pap_regbus_if.sv
// Purpose: Carries register accesses from the bus slave to the port register file.
// Assumes: One write pulse and one combinational read lookup per cycle.
// Notes:   Read data and error answer in the same cycle as the address.
interface pap_regbus_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_be;
    logic       wr_err;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       rd_err;

    modport bus  (output wr_en, wr_addr, wr_data, wr_be, rd_addr, input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_be, rd_addr, output wr_err, rd_data, rd_err);
endinterface : pap_regbus_if

// ### core/pap_axil.sv
// Purpose: AXI4-Lite slave that turns bus transfers into register accesses.
// Assumes: One write and one read under way at a time; data in byte lane 0.
// Notes:   Address and data of a write are taken in either order.
`include "pap_cfg.svh"

module pap_axil (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    pap_regbus_if.bus        rb
);

    pap_pkg::pap_wstate_t wstate_ff, nxt_wstate;
    pap_pkg::pap_rstate_t rstate_ff, nxt_rstate;
    logic                 aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
    logic [7:0]           awaddr_ff;
    logic [7:0]           wdata_ff;
    logic                 wbe_ff;
    logic                 aw_hs, w_hs, ar_hs, do_write;

    // ****************************************************************
    // Write channel
    // ****************************************************************
    // Both halves must be held before the store, so order on the bus does not matter.
    assign aw_hs      = s_awvalid & s_awready;
    assign w_hs       = s_wvalid & s_wready;
    assign do_write   = (wstate_ff == pap_pkg::PAP_WS_COLLECT) & aw_got_ff & w_got_ff;
    assign nxt_aw_got = ~do_write & (aw_got_ff | aw_hs);
    assign nxt_w_got  = ~do_write & (w_got_ff | w_hs);
    assign nxt_wstate = do_write ? pap_pkg::PAP_WS_RESP :
                        (s_bvalid & s_bready) ? pap_pkg::PAP_WS_COLLECT : wstate_ff;
    assign rb.wr_en   = do_write;
    assign rb.wr_addr = awaddr_ff;
    assign rb.wr_data = wdata_ff;
    assign rb.wr_be   = wbe_ff;

    // Ready is registered from the next state so the port comes from a flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wstate_ff <= pap_pkg::PAP_WS_COLLECT;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `PAP_RESP_OKAY;
        end else begin
            wstate_ff <= nxt_wstate;
            aw_got_ff <= nxt_aw_got;
            w_got_ff  <= nxt_w_got;
            s_awready <= ~nxt_aw_got & (nxt_wstate == pap_pkg::PAP_WS_COLLECT);
            s_wready  <= ~nxt_w_got & (nxt_wstate == pap_pkg::PAP_WS_COLLECT);
            s_bvalid  <= nxt_wstate == pap_pkg::PAP_WS_RESP;
            if (do_write) begin
                s_bresp <= rb.wr_err ? `PAP_RESP_SLVERR : `PAP_RESP_OKAY;
            end
        end
    end

    // Payload holders need no reset; they are read only once captured.
    always_ff @(posedge clk) begin
        if (aw_hs) begin
            awaddr_ff <= s_awaddr;
        end
        if (w_hs) begin
            wdata_ff <= s_wdata[7:0];
            wbe_ff   <= s_wstrb[0];
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign ar_hs      = s_arvalid & s_arready;
    assign rb.rd_addr = s_araddr;
    assign nxt_rstate = ar_hs ? pap_pkg::PAP_RS_RESP :
                        (s_rvalid & s_rready) ? pap_pkg::PAP_RS_IDLE : rstate_ff;

    // Upper 24 data bits always read as zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstate_ff <= pap_pkg::PAP_RS_IDLE;
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `PAP_RESP_OKAY;
        end else begin
            rstate_ff <= nxt_rstate;
            s_arready <= nxt_rstate == pap_pkg::PAP_RS_IDLE;
            s_rvalid  <= nxt_rstate == pap_pkg::PAP_RS_RESP;
            if (ar_hs) begin
                s_rdata <= {24'h00_0000, rb.rd_data};
                s_rresp <= rb.rd_err ? `PAP_RESP_SLVERR : `PAP_RESP_OKAY;
            end
        end
    end

endmodule : pap_axil

// ### core/pap_top.sv
// Purpose: Pin logic of an eight-bit general-purpose port with shared alternate functions.
// Assumes: Pin levels are synchronous to clk; neighbours supply their selects as levels.
// Notes:   Pin outputs are registered, so a register change reaches the pins one edge later.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`include "pap_cfg.svh"

module pap_top (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [7:0]            s_awaddr,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire logic [31:0]           s_wdata,
    input  wire logic [3:0]            s_wstrb,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    output logic [1:0]                 s_bresp,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    input  wire logic [7:0]            s_araddr,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    output logic [31:0]                s_rdata,
    output logic [1:0]                 s_rresp,
    output logic                       s_rvalid,
    input  wire logic                  s_rready,
    input  wire logic [7:0]            pin_in,
    output logic [7:0]                 pin_out,
    output logic [7:0]                 pin_oe,
    input  wire logic [7:0]            analog_select,
    input  wire logic                  cmp_out_en,
    input  wire logic                  comparator_one_output,
    input  wire logic                  comparator_two_output,
    input  wire logic                  ref_out_en,
    input  wire logic                  ref_low_in_en,
    input  wire pap_pkg::pap_osc_mode_t osc_mode,
    output logic                       comparator_reference_drive,
    output logic                       slave_select_n,
    output logic                       timer_zero_clock_in
);

    logic [7:0] lat_ff, dir_ff, ana_ff;
    logic [1:0] cyc_cnt_ff;
    logic       cyc_clk_ff;
    logic       boot_ff;
    logic       osc_io6, osc_clk6, osc_io7, ra2_in_off, cyc_tick;
    logic [7:0] ana_all, in_en, rd_pin, nxt_out, nxt_oe;
    logic       rd_sel_pin, rd_sel_lat, rd_sel_dir, rd_sel_ana;
    logic       wr_sel_pin, wr_sel_lat, wr_sel_dir, wr_sel_ana, wr_go;

    pap_regbus_if rb ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Word match on the register bus; the two low address bits are ignored.
    function automatic logic f_hit(input logic [7:0] addr, input logic [7:0] off);
        f_hit = addr[7:2] == off[7:2];
    endfunction : f_hit

    // Hides bits 7 and 6 when the oscillator owns those pins.
    function automatic logic [7:0] f_hide(input logic [7:0] val, input logic io6, input logic io7);
        f_hide = val & {io7, io6, 6'h3f};
    endfunction : f_hide

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    pap_axil u_axil (
        .clk       (clk),
        .rst_n     (rst_n),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .rb        (rb.bus)
    );

    // ****************************************************************
    // Pin ownership
    // ****************************************************************
    // Oscillator decode: which modes leave bits 6 and 7 to the port.
    assign osc_io6    = osc_mode inside {pap_pkg::PAP_OSC_RC_WITH_IO, pap_pkg::PAP_OSC_INT_WITH_IO,
                                         pap_pkg::PAP_OSC_EXT_WITH_IO};
    assign osc_clk6   = osc_mode inside {pap_pkg::PAP_OSC_RC_CLOCK_OUT, pap_pkg::PAP_OSC_INT_CLOCK_OUT,
                                         pap_pkg::PAP_OSC_EXT_CLOCK_OUT};
    assign osc_io7    = osc_mode inside {pap_pkg::PAP_OSC_INT_CLOCK_OUT, pap_pkg::PAP_OSC_INT_WITH_IO};
    // Analog ownership is the own select register or the converter's live select.
    assign ana_all    = (ana_ff | analog_select) & `PAP_ANA_MASK;
    assign ra2_in_off = ref_low_in_en | ref_out_en;
    // Input buffers: analog, reference and oscillator uses all switch them off.
    assign in_en      = ~ana_all & {osc_io7, osc_io6, 3'h7, ~ra2_in_off, 2'h3};
    assign rd_pin     = pin_in & in_en;

    // Drivers: direction 0 drives unless an override owns the pin; analog select plays no part.
    assign nxt_oe     = (~dir_ff & {osc_io7, osc_io6, 3'h7, ~ref_out_en, 2'h3})
                      | {1'b0, osc_clk6, 6'h00};
    // Comparator outputs take priority over latch data on bits 4 and 5.
    assign nxt_out    = {lat_ff[`PAP_BIT_OSC_IN],
                         osc_clk6 ? cyc_clk_ff : lat_ff[`PAP_BIT_OSC_FB],
                         cmp_out_en ? comparator_two_output : lat_ff[`PAP_BIT_C2],
                         cmp_out_en ? comparator_one_output : lat_ff[`PAP_BIT_C1],
                         lat_ff[3:0]};

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign rd_sel_pin = f_hit(rb.rd_addr, `PAP_OFF_PIN);
    assign rd_sel_lat = f_hit(rb.rd_addr, `PAP_OFF_LAT);
    assign rd_sel_dir = f_hit(rb.rd_addr, `PAP_OFF_DIR);
    assign rd_sel_ana = f_hit(rb.rd_addr, `PAP_OFF_ANA);
    assign wr_sel_pin = f_hit(rb.wr_addr, `PAP_OFF_PIN);
    assign wr_sel_lat = f_hit(rb.wr_addr, `PAP_OFF_LAT);
    assign wr_sel_dir = f_hit(rb.wr_addr, `PAP_OFF_DIR);
    assign wr_sel_ana = f_hit(rb.wr_addr, `PAP_OFF_ANA);
    assign wr_go      = rb.wr_en & rb.wr_be;
    assign rb.wr_err  = ~(wr_sel_pin | wr_sel_lat | wr_sel_dir | wr_sel_ana);
    assign rb.rd_err  = ~(rd_sel_pin | rd_sel_lat | rd_sel_dir | rd_sel_ana);
    // Pin read shows levels, latch read shows the latch; oscillator pins hide as zero.
    assign rb.rd_data = rd_sel_pin ? f_hide(rd_pin, osc_io6, osc_io7) :
                        rd_sel_lat ? f_hide(lat_ff, osc_io6, osc_io7) :
                        rd_sel_dir ? f_hide(dir_ff, osc_io6, osc_io7) :
                        rd_sel_ana ? ana_ff : 8'h00;

    // ****************************************************************
    // Registers
    // ****************************************************************
    // A write to the pin register lands in the latch, just as a latch write does.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_ff <= `PAP_RST_LAT;
            dir_ff <= `PAP_RST_DIR;
            ana_ff <= `PAP_RST_ANA;
        end else if (wr_go) begin
            if (wr_sel_pin | wr_sel_lat) begin
                lat_ff <= rb.wr_data;
            end
            if (wr_sel_dir) begin
                dir_ff <= rb.wr_data;
            end
            if (wr_sel_ana) begin
                ana_ff <= rb.wr_data & `PAP_ANA_MASK;
            end
        end
    end

    // ****************************************************************
    // Cycle clock divider
    // ****************************************************************
    // The enable ticks every half period, so the output toggles at clk divided by four.
    assign cyc_tick = cyc_cnt_ff == (`PAP_CYC_HALF - 2'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt_ff <= 2'h0;
            cyc_clk_ff <= 1'b0;
        end else begin
            cyc_cnt_ff <= cyc_tick ? 2'h0 : cyc_cnt_ff + 2'h1;
            cyc_clk_ff <= cyc_clk_ff ^ cyc_tick;
        end
    end

    // ****************************************************************
    // Registered pin and side outputs
    // ****************************************************************
    // Registering costs a cycle of latency but keeps glitches off the pads.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out                    <= 8'h00;
            pin_oe                     <= 8'h00;
            comparator_reference_drive <= 1'b0;
            slave_select_n             <= 1'b1;
            timer_zero_clock_in        <= 1'b0;
            boot_ff                    <= 1'b0;
        end else begin
            pin_out                    <= nxt_out;
            pin_oe                     <= nxt_oe;
            comparator_reference_drive <= ref_out_en;
            slave_select_n             <= dir_ff[`PAP_BIT_C2] ? pin_in[`PAP_BIT_C2] : 1'b1;
            timer_zero_clock_in        <= pin_in[`PAP_BIT_C1];
            boot_ff                    <= 1'b1;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_LATCH_DRIVE: assert property (!dir_ff[0] |=> pin_oe[0] && pin_out[0] == $past(lat_ff[0]))
        else $error("Bit 0 output does not follow the latch.");
    AST_ANALOG_READ_ZERO: assert property (ana_all[1] |-> rd_pin[1] == 1'b0)
        else $error("Analog pin reads nonzero.");
    AST_RESET_ANALOG: assert property (!boot_ff |-> ana_ff == `PAP_RST_ANA && dir_ff == `PAP_RST_DIR)
        else $error("Analog configuration wrong after reset.");
    AST_BIT4_DIGITAL: assert property (!boot_ff |-> in_en[`PAP_BIT_C1] && dir_ff[`PAP_BIT_C1] &&
                                       ana_all[`PAP_BIT_C2])
        else $error("Bit 4 is not digital after reset.");
    AST_CMP_OVERRIDE: assert property (cmp_out_en && !dir_ff[`PAP_BIT_C1] |=>
                                       pin_oe[`PAP_BIT_C1] && pin_out[`PAP_BIT_C1] == $past(comparator_one_output))
        else $error("Comparator one does not own bit 4.");
    AST_REF_NO_DIGITAL: assert property (ref_out_en |=> !pin_oe[`PAP_BIT_VREF] && comparator_reference_drive)
        else $error("Bit 2 driven while reference output is on.");
    AST_RA2_INPUT_OFF: assert property (ref_low_in_en |-> rd_pin[`PAP_BIT_VREF] == 1'b0)
        else $error("Bit 2 input alive during analog use.");
    AST_BIT7_OFF: assert property (!osc_io7 |=> !pin_oe[`PAP_BIT_OSC_IN])
        else $error("Bit 7 driven in an external oscillator mode.");
    AST_HIDE_OSC: assert property (!osc_io6 && rd_sel_dir |-> rb.rd_data[`PAP_BIT_OSC_FB] == 1'b0)
        else $error("Bit 6 direction visible while owned by oscillator.");
    AST_CLOCK_OUT: assert property (osc_clk6 [*4] |-> pin_oe[`PAP_BIT_OSC_FB] &&
                                    pin_out[`PAP_BIT_OSC_FB] != $past(pin_out[`PAP_BIT_OSC_FB], 2))
        else $error("Bit 6 clock output is not at a quarter rate.");
    AST_SLAVE_SELECT: assert property (dir_ff[`PAP_BIT_C2] |=> slave_select_n == $past(pin_in[`PAP_BIT_C2]))
        else $error("Slave select does not follow bit 5.");
    AST_PIN_WRITE: assert property (wr_go && wr_sel_pin |=> lat_ff == $past(rb.wr_data))
        else $error("Pin register write missed the latch.");

    COV_CLOCK_OUT: cover property (osc_clk6 [*4]);
    COV_CMP_OUT:   cover property (cmp_out_en && !dir_ff[`PAP_BIT_C2] ##1 pin_oe[`PAP_BIT_C2]);
    COV_WRITE:     cover property (wr_go && wr_sel_lat ##[1:20] s_rvalid && s_rready);
    COV_REF_OUT:   cover property (ref_out_en ##1 comparator_reference_drive);

endmodule : pap_top

// ### tb/pap_board.sv
// Purpose: Board model that drives every port pin the device leaves released.
// Assumes: The bench sets the board levels; the pins have no pull resistors.
// Notes:   A pin the device drives reads back its own drive value.
module pap_board (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] board_level,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each pin takes the device drive where enabled and the board level elsewhere.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule : pap_board

// ### tb/eight_bit_port_a_pin_logic_tb_top.sv
// Purpose: Self-checking bench of the port pin logic and its register bus.
// Assumes: Pin outputs settle within two edges of a register or select change.
// Notes:   Table rows hold ordinary setups; reset and masks are checked by hand before them, clock out and a second reset after.
`include "pap_cfg.svh"
module eight_bit_port_a_pin_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] md, cm, es;
        logic [1:0] rf;
        logic [7:0] an, lat, dir, brd, oe, out, pin, lrd, drd;
    } pap_row_t;
    logic        clk, rst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
    logic        s_rvalid, s_rready, cmp_out_en, comparator_one_output, comparator_two_output, ref_out_en;
    logic        ref_low_in_en, comparator_reference_drive, slave_select_n, timer_zero_clock_in, b0, aw_p, w_p;
    logic [1:0]  s_bresp, s_rresp;
    logic [3:0]  s_wstrb;
    logic [7:0]  s_awaddr, s_araddr, pin_in, pin_out, pin_oe, analog_select, board_level;
    logic [31:0] s_wdata, s_rdata;
    int          fail_count = 0, checks = 0, cycles = 0;
    pap_pkg::pap_osc_mode_t osc_mode;
    pap_row_t    r;
    // Rows: mode, comparator, side outputs, reference, analog, latch, direction, board, then expectations.
    localparam pap_row_t ROWS [8] = '{'{3'h4,3'h0,3'h2,2'h0,8'h00,8'ha5,8'h0f,8'h3c,8'hf0,8'ha0,8'hac,8'ha5,8'h0f},
        '{3'h4,3'h0,3'h2,2'h0,8'h2f,8'h0f,8'h00,8'hff,8'hff,8'h0f,8'h00,8'h0f,8'h00},
        '{3'h4,3'h6,3'h2,2'h0,8'h00,8'h10,8'hcf,8'h00,8'h30,8'h20,8'h20,8'h10,8'hcf},
        '{3'h4,3'h0,3'h7,2'h2,8'h00,8'hff,8'h00,8'h00,8'hfb,8'hfb,8'hfb,8'hff,8'h00},
        '{3'h4,3'h0,3'h1,2'h1,8'h00,8'h00,8'hff,8'hdf,8'h00,8'h00,8'hdb,8'h00,8'hff},
        '{3'h0,3'h0,3'h3,2'h0,8'h00,8'hff,8'hc0,8'hff,8'h3f,8'h3f,8'h3f,8'h3f,8'h00},
        '{3'h6,3'h0,3'h3,2'h0,8'h00,8'hff,8'h80,8'hff,8'h7f,8'h7f,8'h7f,8'h7f,8'h00},
        '{3'h2,3'h0,3'h3,2'h0,8'h00,8'hff,8'h80,8'hff,8'h7f,8'h7f,8'h7f,8'h7f,8'h00}};
    pap_top dut_u (
        .clk(clk), .rst_n(rst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_select(analog_select),
        .cmp_out_en(cmp_out_en), .comparator_one_output(comparator_one_output),
        .comparator_two_output(comparator_two_output), .ref_out_en(ref_out_en), .ref_low_in_en(ref_low_in_en),
        .osc_mode(osc_mode), .comparator_reference_drive(comparator_reference_drive),
        .slave_select_n(slave_select_n), .timer_zero_clock_in(timer_zero_clock_in)
    );
    pap_board board_u (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board_level), .pin_in(pin_in));
    // ****************************************************************
    // Bus tasks and checking
    // ****************************************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Ready is registered, so seeing it at the falling edge means the next rising edge takes the item.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] sb, input logic [1:0] er);
        {s_awaddr, s_wdata, s_wstrb, s_awvalid, s_wvalid} <= {a, 24'h0, d, sb, 2'b11};
        {aw_p, w_p} = 2'b11;
        while (aw_p || w_p) begin
            @(negedge clk);
            {aw_p, w_p} = {aw_p && (s_awready !== 1'b1), w_p && (s_wready !== 1'b1)};
            @(posedge clk);
            {s_awvalid, s_wvalid} <= {aw_p, w_p};
        end
        do @(negedge clk); while (s_bvalid !== 1'b1);
        chk(s_bresp, er);
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        {s_araddr, s_arvalid} <= {a, 1'b1};
        do @(negedge clk); while (s_arready !== 1'b1);
        @(posedge clk);
        s_arvalid <= 1'b0;
        do @(negedge clk); while (s_rvalid !== 1'b1);
        chk(s_rdata, {24'h0, e});
        chk(s_rresp, er);
        @(posedge clk);
    endtask : rd
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The whole run needs well under a thousand cycles; a hang is cut off far above that.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        {rst_n, s_awvalid, s_wvalid, s_arvalid, s_bready, s_rready} = 6'h3;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        {analog_select, cmp_out_en, comparator_one_output, comparator_two_output, ref_out_en, ref_low_in_en} = '0;
        board_level = 8'hff;
        osc_mode = pap_pkg::PAP_OSC_INT_WITH_IO;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(pin_oe, 8'h00);
        @(posedge clk);
        rd(`PAP_OFF_PIN, 8'hd0, `PAP_RESP_OKAY);
        rd(`PAP_OFF_DIR, 8'hff, `PAP_RESP_OKAY);
        rd(`PAP_OFF_ANA, 8'h2f, `PAP_RESP_OKAY);
        wr(`PAP_OFF_LAT, 8'hff, 4'h0, `PAP_RESP_OKAY);
        rd(`PAP_OFF_LAT, 8'h00, `PAP_RESP_OKAY);
        wr(`PAP_OFF_ANA, 8'hff, 4'h1, `PAP_RESP_OKAY);
        rd(`PAP_OFF_ANA, 8'h2f, `PAP_RESP_OKAY);
        wr(`PAP_OFF_ANA, 8'h00, 4'h1, `PAP_RESP_OKAY);
        wr(8'h10, 8'h5a, 4'h1, `PAP_RESP_SLVERR);
        rd(8'h10, 8'h00, `PAP_RESP_SLVERR);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            osc_mode <= pap_pkg::pap_osc_mode_t'(r.md);
            {analog_select, cmp_out_en, comparator_two_output, comparator_one_output} <= {r.an, r.cm};
            {ref_out_en, ref_low_in_en, board_level} <= {r.rf, r.brd};
            wr(`PAP_OFF_PIN, r.lat, 4'h1, `PAP_RESP_OKAY);
            wr(`PAP_OFF_DIR, r.dir, 4'h1, `PAP_RESP_OKAY);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk(pin_oe, r.oe);
            chk(pin_out & pin_oe, r.out);
            chk({comparator_reference_drive, slave_select_n, timer_zero_clock_in}, r.es);
            @(posedge clk);
            rd(`PAP_OFF_PIN, r.pin, `PAP_RESP_OKAY);
            rd(`PAP_OFF_LAT, r.lrd, `PAP_RESP_OKAY);
            rd(`PAP_OFF_DIR, r.drd, `PAP_RESP_OKAY);
        end
        // Clock-out modes must drive bit 6 even with its direction bit set to input.
        wr(`PAP_OFF_DIR, 8'hff, 4'h1, `PAP_RESP_OKAY);
        for (int m = 1; m < 6; m += 2) begin
            osc_mode <= pap_pkg::pap_osc_mode_t'(m);
            repeat (3) @(posedge clk);
            @(negedge clk);
            b0 = pin_out[6];
            chk(pin_oe[6], 1'b1);
            repeat (2) @(negedge clk);
            chk(pin_out[6], !b0);
            repeat (2) @(negedge clk);
            chk(pin_out[6], b0);
            @(posedge clk);
            rd(`PAP_OFF_LAT, {m == 3, 7'h3f}, `PAP_RESP_OKAY);
        end
        // A mid-run reset must bring back the power-up setup; no clock-out mode across it.
        osc_mode <= pap_pkg::PAP_OSC_INT_WITH_IO;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(pin_oe, 8'h00);
        @(posedge clk);
        rd(`PAP_OFF_ANA, 8'h2f, `PAP_RESP_OKAY);
        close_out();
    end
endmodule : eight_bit_port_a_pin_logic_tb_top
